// ### rtl/ssf_pkg.sv
// package: constants, register map and types for the servo status flag block
package ssf_pkg;
  // clock and power-on timing
  localparam int unsigned SSF_CLK_HZ = 100_000_000;
  localparam int unsigned SSF_MALF_MIN_S = 4;
  localparam int unsigned SSF_MALF_MAX_S = 5;
  localparam int unsigned SSF_PWRON_CYCLES = SSF_MALF_MIN_S * SSF_CLK_HZ;
  // register byte offsets
  localparam logic [7:0] SSF_CTRL_OFS = 8'h00;
  localparam logic [7:0] SSF_RANGE_LO_OFS = 8'h04;
  localparam logic [7:0] SSF_RANGE_HI_OFS = 8'h08;
  localparam logic [7:0] SSF_GEAR_NUM_OFS = 8'h0c;
  localparam logic [7:0] SSF_GEAR_DEN_OFS = 8'h10;
  localparam logic [7:0] SSF_POS_CMD_OFS = 8'h14;
  localparam logic [7:0] SSF_SPD_CMD_OFS = 8'h18;
  localparam logic [7:0] SSF_STATUS_OFS = 8'h1c;
  localparam logic [7:0] SSF_POS_ACT_OFS = 8'h20;
  localparam logic [7:0] SSF_SPD_ACT_OFS = 8'h24;
  // field positions and reset values
  localparam int unsigned SSF_CTRL_ABS_BIT = 0;
  localparam logic [31:0] SSF_RANGE_LO_RST = 32'h0000_0000;
  localparam logic [31:0] SSF_RANGE_HI_RST = 32'h0000_0000;
  localparam logic [31:0] SSF_GEAR_NUM_RST = 32'h0000_0001;
  localparam logic [31:0] SSF_GEAR_DEN_RST = 32'h0000_0001;
  localparam logic [31:0] SSF_ZERO_RST = 32'h0000_0000;
  localparam int unsigned SSF_STATUS_BITS = 6;
  // cyclic status flags seen by the network master
  typedef struct packed {
    logic comm_ready;
    logic malfunction;
    logic speed_cmd_done;
    logic position_cmd_done;
    logic home_return_done;
    logic position_range_flag;
  } ssf_flags_type;
endpackage

// ### rtl/ssf_status_flags.sv
// servo status flag generator with an Avalon-MM register slave
//
// Operation
// (RQ1) Range flag is high while actual position lies within the range bounds.
// (RQ2) Range flag forced low without completed home return or during shut-off.
// (RQ3) Home-done flag sets on normal home return, holds until erased.
// (RQ4) Incremental system: command error alarm or no home return clears home-done.
// (RQ5) Absolute system: erased alarm plus counter warning clear home-done.
// (RQ6) Changing either gear ratio parameter clears home-done until new return.
// (RQ7) Changing absolute detection selection clears home-done until new return.
// (RQ8) Malfunction flag is high whenever an alarm is present.
// (RQ9) Without alarm, malfunction drops four to five seconds after power-on.
// (RQ10) Communication ready flag rises when power is applied.
// (RQ11) Communication ready flag drops whenever an alarm occurs.
// (RQ12) Master loads command data, raises demand; completion flag follows the write.
// (RQ13) All flags evaluated each clock and presented from flip-flops.
`timescale 1ns/100ps
module ssf_status_flags
  import ssf_pkg::*;
#(
  parameter int unsigned PWRON_CYCLES = SSF_PWRON_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // servo state from the amplifier core
  input wire logic [31:0] actual_position,
  input wire logic base_shutoff,
  input wire logic alarm_active,
  input wire logic home_return_ok,
  input wire logic home_erase,
  input wire logic command_error_alarm,
  input wire logic abs_position_erased_alarm,
  input wire logic abs_counter_warning,
  // command demands from the network master
  input wire logic position_cmd_demand,
  input wire logic speed_cmd_demand,
  // cyclic status flags
  output ssf_flags_type status_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic waitreq_reg;
  logic [31:0] rdata_reg;
  logic abs_sel_reg;
  logic [31:0] range_lo_reg;
  logic [31:0] range_hi_reg;
  logic [31:0] gear_num_reg;
  logic [31:0] gear_den_reg;
  logic [31:0] pos_cmd_reg;
  logic [31:0] spd_cmd_reg;
  logic [31:0] pos_act_reg;
  logic [31:0] spd_act_reg;
  logic [31:0] pwron_cnt_reg;
  logic pwron_done_reg;
  logic abs_erased_seen_reg;
  logic abs_warn_seen_reg;
  ssf_flags_type flags_reg;
  ssf_flags_type flags_next;
  logic req;
  logic wr_go;
  logic gear_changed;
  logic abs_sel_changed;
  logic home_clear;
  logic in_range;
  logic [31:0] ctrl_next;
  logic [31:0] gear_num_next;
  logic [31:0] gear_den_next;

  // merge write data into a register under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // write strobe for one offset, only at the edge that completes the access
  function automatic logic wr_hit(input logic go, input logic [7:0] adr,
                                  input logic [7:0] ofs);
    return go && (adr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the access completes
  assign req = avs_read || avs_write;
  assign wr_go = avs_write && !waitreq_reg;

  // waitrequest drops for exactly one cycle per access so a held request
  // is never taken twice
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitreq_reg <= 1'b1;
    end else if (req && waitreq_reg) begin
      waitreq_reg <= 1'b0;
    end else begin
      waitreq_reg <= 1'b1;
    end
  end

  // read data is captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= SSF_ZERO_RST;
    end else if (avs_read && waitreq_reg) begin
      if (avs_address == SSF_CTRL_OFS) begin
        rdata_reg <= {31'h0000_0000, abs_sel_reg};
      end else if (avs_address == SSF_RANGE_LO_OFS) begin
        rdata_reg <= range_lo_reg;
      end else if (avs_address == SSF_RANGE_HI_OFS) begin
        rdata_reg <= range_hi_reg;
      end else if (avs_address == SSF_GEAR_NUM_OFS) begin
        rdata_reg <= gear_num_reg;
      end else if (avs_address == SSF_GEAR_DEN_OFS) begin
        rdata_reg <= gear_den_reg;
      end else if (avs_address == SSF_POS_CMD_OFS) begin
        rdata_reg <= pos_cmd_reg;
      end else if (avs_address == SSF_SPD_CMD_OFS) begin
        rdata_reg <= spd_cmd_reg;
      end else if (avs_address == SSF_STATUS_OFS) begin
        rdata_reg <= {26'h000_0000, flags_reg};
      end else if (avs_address == SSF_POS_ACT_OFS) begin
        rdata_reg <= pos_act_reg;
      end else if (avs_address == SSF_SPD_ACT_OFS) begin
        rdata_reg <= spd_act_reg;
      end else begin
        rdata_reg <= SSF_ZERO_RST;
      end
    end
  end

  assign avs_waitrequest = waitreq_reg;
  assign avs_readdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and change detection
  assign ctrl_next = be_merge({31'h0000_0000, abs_sel_reg}, avs_writedata,
                              avs_byteenable);
  assign gear_num_next = be_merge(gear_num_reg, avs_writedata,
                                  avs_byteenable);
  assign gear_den_next = be_merge(gear_den_reg, avs_writedata,
                                  avs_byteenable);
  // rewriting the same value is not a change and keeps the home position
  assign gear_changed =
    (wr_hit(wr_go, avs_address, SSF_GEAR_NUM_OFS) &&
     (gear_num_next != gear_num_reg)) ||
    (wr_hit(wr_go, avs_address, SSF_GEAR_DEN_OFS) &&
     (gear_den_next != gear_den_reg));
  assign abs_sel_changed = wr_hit(wr_go, avs_address, SSF_CTRL_OFS) &&
                           (ctrl_next[SSF_CTRL_ABS_BIT] != abs_sel_reg);

  // software-written configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abs_sel_reg <= 1'b0;
      range_lo_reg <= SSF_RANGE_LO_RST;
      range_hi_reg <= SSF_RANGE_HI_RST;
      gear_num_reg <= SSF_GEAR_NUM_RST;
      gear_den_reg <= SSF_GEAR_DEN_RST;
      pos_cmd_reg <= SSF_ZERO_RST;
      spd_cmd_reg <= SSF_ZERO_RST;
    end else begin
      if (wr_hit(wr_go, avs_address, SSF_CTRL_OFS)) begin
        abs_sel_reg <= ctrl_next[SSF_CTRL_ABS_BIT];
      end
      if (wr_hit(wr_go, avs_address, SSF_RANGE_LO_OFS)) begin
        range_lo_reg <= be_merge(range_lo_reg, avs_writedata,
                                 avs_byteenable);
      end
      if (wr_hit(wr_go, avs_address, SSF_RANGE_HI_OFS)) begin
        range_hi_reg <= be_merge(range_hi_reg, avs_writedata,
                                 avs_byteenable);
      end
      if (wr_hit(wr_go, avs_address, SSF_GEAR_NUM_OFS)) begin
        gear_num_reg <= gear_num_next;
      end
      if (wr_hit(wr_go, avs_address, SSF_GEAR_DEN_OFS)) begin
        gear_den_reg <= gear_den_next;
      end
      if (wr_hit(wr_go, avs_address, SSF_POS_CMD_OFS)) begin
        pos_cmd_reg <= be_merge(pos_cmd_reg, avs_writedata, avs_byteenable);
      end
      if (wr_hit(wr_go, avs_address, SSF_SPD_CMD_OFS)) begin
        spd_cmd_reg <= be_merge(spd_cmd_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution: demand copies staged data into the active command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_act_reg <= SSF_ZERO_RST;
      spd_act_reg <= SSF_ZERO_RST;
    end else begin
      if (position_cmd_demand) begin
        pos_act_reg <= pos_cmd_reg; // RQ12
      end
      if (speed_cmd_demand) begin
        spd_act_reg <= spd_cmd_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on timer; the malfunction flag stays up until it expires
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwron_cnt_reg <= SSF_ZERO_RST;
      pwron_done_reg <= 1'b0;
    end else if (!pwron_done_reg) begin
      pwron_cnt_reg <= pwron_cnt_reg + 32'h0000_0001;
      pwron_done_reg <= (pwron_cnt_reg == 32'(PWRON_CYCLES - 1)); // RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // absolute alarm history: both events must have occurred, in any order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      abs_erased_seen_reg <= 1'b0;
      abs_warn_seen_reg <= 1'b0;
    end else if (home_return_ok) begin
      // an alarm landing with the home return still counts: set wins
      abs_erased_seen_reg <= abs_position_erased_alarm;
      abs_warn_seen_reg <= abs_counter_warning;
    end else begin
      abs_erased_seen_reg <= abs_erased_seen_reg || abs_position_erased_alarm;
      abs_warn_seen_reg <= abs_warn_seen_reg || abs_counter_warning;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag evaluation
  assign in_range = ($signed(actual_position) >= $signed(range_lo_reg)) &&
                    ($signed(actual_position) <= $signed(range_hi_reg));
  assign home_clear = home_erase || command_error_alarm || // RQ4
                      (abs_sel_reg && abs_erased_seen_reg &&
                       abs_warn_seen_reg) || // RQ5
                      gear_changed || // RQ6
                      abs_sel_changed; // RQ7

  always_comb begin
    flags_next = flags_reg;
    // a normal completion in the same cycle as a clear wins
    if (home_return_ok) begin
      flags_next.home_return_done = 1'b1; // RQ3
    end else if (home_clear) begin
      flags_next.home_return_done = 1'b0;
    end
    // gate on the next home state so range never outlives a cleared home
    flags_next.position_range_flag = in_range && // RQ1
                                     flags_next.home_return_done &&
                                     !base_shutoff; // RQ2
    flags_next.position_cmd_done = position_cmd_demand; // RQ12
    flags_next.speed_cmd_done = speed_cmd_demand;
    flags_next.malfunction = alarm_active || !pwron_done_reg; // RQ8
    flags_next.comm_ready = !alarm_active; // RQ11
  end

  // every flag is refreshed each clock so the master sees one coherent set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= '{comm_ready: 1'b1, malfunction: 1'b1, default: 1'b0};
    end else begin
      flags_reg <= flags_next; // RQ13
    end
  end

  assign status_flags = flags_reg; // RQ10

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  range_gate_a: assert property ((!flags_next.home_return_done ||
    base_shutoff) |=> !status_flags.position_range_flag) // RQ2
    else $error("range flag high without home or in shut-off");
  range_home_a: assert property (status_flags.position_range_flag
    |-> status_flags.home_return_done) // RQ2
    else $error("range flag high while home done is low");
  range_hit_a: assert property ((in_range && flags_next.home_return_done &&
    !base_shutoff) |=> status_flags.position_range_flag) // RQ1
    else $error("range flag missing while in range");
  home_set_a: assert property (home_return_ok
    |=> status_flags.home_return_done) // RQ3
    else $error("home done not set after return");
  home_cmderr_a: assert property ((command_error_alarm && !home_return_ok)
    |=> !status_flags.home_return_done) // RQ4
    else $error("home done survived command error");
  home_abs_a: assert property ((abs_sel_reg && abs_erased_seen_reg &&
    abs_warn_seen_reg && !home_return_ok)
    |=> !status_flags.home_return_done) // RQ5
    else $error("home done survived absolute alarms");
  home_gear_a: assert property ((gear_changed && !home_return_ok)
    |=> !status_flags.home_return_done) // RQ6
    else $error("home done survived gear change");
  home_sel_a: assert property ((abs_sel_changed && !home_return_ok)
    |=> !status_flags.home_return_done) // RQ7
    else $error("home done survived selection change");
  malf_alarm_a: assert property (alarm_active
    |=> status_flags.malfunction && !status_flags.comm_ready) // RQ8 RQ11
    else $error("alarm not reflected in flags");
  malf_release_a: assert property ($rose(pwron_done_reg) && !alarm_active
    |=> !status_flags.malfunction) // RQ9
    else $error("malfunction not released after power-on time");
  pos_done_a: assert property ($rose(position_cmd_demand)
    |=> status_flags.position_cmd_done &&
        (pos_act_reg == $past(pos_cmd_reg))) // RQ12
    else $error("position completion without written data");
  bus_wait_a: assert property (req && waitreq_reg
    |=> !avs_waitrequest ##1 avs_waitrequest) // bus handshake: waitrequest low for one cycle
    else $error("waitrequest not one cycle low");

  home_cycle_c: cover property (home_return_ok ##[1:20] home_clear);
  pos_cmd_c: cover property ($rose(position_cmd_demand) ##1
    $fell(position_cmd_demand));
  alarm_c: cover property ($rose(alarm_active) ##[1:10] $fell(alarm_active));
  bus_wr_c: cover property (wr_go);

endmodule

// ### verif/ssf_master_model.sv
// network master model: raises command demands, drops them on completion
`timescale 1ns/100ps
module ssf_master_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // start requests from the bench, completions from the device
  input wire logic [1:0] go,
  input wire logic [1:0] cmd_done,
  // demands to the device, bit 0 position, bit 1 speed
  output logic [1:0] demand
);
  //////////////////////////////////////////////////////////////////////
  // demand only rises once the bench has staged the command data, and
  // stays up until completion is seen, as a real master would hold it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      demand <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (go[i]) begin
          demand[i] <= 1'b1;
        end else if (demand[i] && cmd_done[i]) begin
          demand[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// ### verif/ssf_status_flags_tb_top.sv
// self-checking bench for the servo status flag generator
`timescale 1ns/100ps
module ssf_status_flags_tb_top
  import ssf_pkg::*;
;
  localparam int unsigned PWR = 20; // short power-on count for simulation
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] actual_position = 32'h0000_0000;
  logic base_shutoff = 1'b0;
  logic alarm_active = 1'b0;
  logic [4:0] ev = 5'h00; // home ok, erase, cmd error, abs erased, abs warn
  logic [1:0] go = 2'h0;
  logic [1:0] demand;
  ssf_flags_type status_flags;
  logic [5:0] fl;
  logic [31:0] mem_m [16];
  logic [31:0] pts [4] = '{32'hffff_ff00, 32'h0000_0100, 32'hffff_feff,
                           32'h0000_0101};
  logic [31:0] rd;
  int home_m = 0;
  int seed = 32'hfec0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  assign fl = status_flags;

  //////////////////////////////////////////////////////////////////////
  // device under test and the master model on its command side
  ssf_status_flags #(.PWRON_CYCLES(PWR)) dut (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .actual_position(actual_position), .base_shutoff(base_shutoff),
    .alarm_active(alarm_active), .home_return_ok(ev[0]),
    .home_erase(ev[1]), .command_error_alarm(ev[2]),
    .abs_position_erased_alarm(ev[3]), .abs_counter_warning(ev[4]),
    .position_cmd_demand(demand[0]), .speed_cmd_demand(demand[1]),
    .status_flags(status_flags));
  ssf_master_model master (.clk(clk), .rst_b(rst_b), .go(go),
    .cmd_done(fl[3:2]), .demand(demand));

  //////////////////////////////////////////////////////////////////////
  // clock and hang guard; the whole run needs well under 3000 cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_mismatch++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low, released only then
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    // no cycle count assumed: a hung slave is caught by the bench timeout
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // write with byte-lane merge into the model; only changed values clear
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] nv;
    nv = mem_m[a[5:2]];
    for (int i = 0; i < 4; i++) if (be[i]) nv[8*i+:8] = d[8*i+:8];
    bus(1'b1, a, d, be);
    if (a <= SSF_SPD_CMD_OFS) begin
      if ((a == SSF_GEAR_NUM_OFS || a == SSF_GEAR_DEN_OFS) &&
          nv !== mem_m[a[5:2]]) home_m = 0;
      if (a == SSF_CTRL_OFS && nv[0] !== mem_m[0][0]) home_m = 0;
      mem_m[a[5:2]] = nv;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'h0);
    check(rd, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  // flags predicted from the current inputs and the model state
  function automatic logic [31:0] exp_flags();
    logic rng;
    rng = home_m != 0 && !base_shutoff &&
          $signed(actual_position) >= $signed(mem_m[1]) &&
          $signed(actual_position) <= $signed(mem_m[2]);
    return {26'h0, !alarm_active, alarm_active, 2'b00, home_m != 0, rng};
  endfunction

  // three edges let every flag settle after the inputs have moved
  task automatic flags_chk();
    repeat (3) @(posedge clk);
    check({26'h0, fl}, exp_flags());
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int k;
    logic [31:0] v;
    for (int i = 0; i < 16; i++) mem_m[i] = SSF_ZERO_RST;
    mem_m[3] = SSF_GEAR_NUM_RST;
    mem_m[4] = SSF_GEAR_DEN_RST;
    repeat (8) @(posedge clk);
    check({26'h0, fl}, 32'h0000_0030);
    rst_b <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (fl[4] !== 1'b0 && k < 100);
    check(32'(k >= PWR + 1 && k <= PWR + 4), 32'h0000_0001);
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), mem_m[i]);
    rdchk(8'h40, 32'h0000_0000);
    wr(SSF_RANGE_LO_OFS, pts[0], 4'hf);
    wr(SSF_RANGE_HI_OFS, pts[1], 4'hf);
    actual_position <= 32'h0000_0010;
    flags_chk();
    pulse(0);
    home_m = 1;
    flags_chk();
    for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? pts[i] : 32'($random(seed) % 400);
      actual_position <= v;
      flags_chk();
    end
    base_shutoff <= 1'b1;
    actual_position <= 32'h0000_0000;
    flags_chk();
    base_shutoff <= 1'b0;
    pulse(1);
    home_m = 0;
    flags_chk();
    pulse(0);
    pulse(2);
    home_m = 0;
    flags_chk();
    // absolute system: both events needed, history restarts on home return
    wr(SSF_CTRL_OFS, 32'h0000_0001, 4'hf);
    pulse(0);
    home_m = 1;
    pulse(3);
    flags_chk();
    pulse(4);
    home_m = 0;
    flags_chk();
    pulse(0);
    home_m = 1;
    pulse(4);
    flags_chk();
    wr(SSF_CTRL_OFS, 32'h0000_0000, 4'hf);
    flags_chk();
    pulse(0);
    home_m = 1;
    wr(SSF_GEAR_NUM_OFS, 32'h0000_0001, 4'hf);
    flags_chk();
    wr(SSF_GEAR_DEN_OFS, 32'h0000_0500, 4'h2);
    flags_chk();
    rdchk(SSF_GEAR_DEN_OFS, mem_m[4]);
    wr(SSF_STATUS_OFS, 32'hffff_ffff, 4'hf);
    wr(8'h40, 32'hffff_ffff, 4'hf);
    rdchk(8'h40, 32'h0000_0000);
    rdchk(SSF_STATUS_OFS, exp_flags());
    alarm_active <= 1'b1;
    flags_chk();
    alarm_active <= 1'b0;
    flags_chk();
    // commands: data staged first, then the master raises its demand
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      wr(i ? SSF_SPD_CMD_OFS : SSF_POS_CMD_OFS, v, 4'hf);
      go[i] <= 1'b1;
      @(posedge clk);
      go[i] <= 1'b0;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (fl[2+i] !== 1'b1 && k < 20);
      check(32'(k), 32'h0000_0002);
      rdchk(i ? SSF_SPD_ACT_OFS : SSF_POS_ACT_OFS, v);
      flags_chk();
    end
    test_done();
  end
endmodule
